// ---- logic/adc_ctrl_params.svh ----
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH
// What this block does
// - Power byte: 0 off, 1 low, 2 medium, 3 high
// - Integrators stay powered down until start
// - Start initializes and applies supplied power level
// - Stop powers off integrators, disables counting logic
// - Power level changes allowed while converting
// - Resolution 7 to 13; writing it halts conversion
// - Without runtime write, static resolution applies
// - Sampling command collects exactly given 8-bit count
// - Count zero means convert continuously until halted
// - Halt abandons conversion in progress immediately
// - Ready status nonzero after completed conversion only
// - Channel one read returns latest input one result
// - Channel two read returns latest input two result
// - Each conversion overwrites held results; read promptly
// - Clear command zeroes ready, keeps held results
// - Read-and-clear reads clear the same ready flag
// - Unsigned 0..2^N-1, signed -2^(N-1)..2^(N-1)-1

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define OFS_COMMAND 8'h00
`define OFS_POWER 8'h04
`define OFS_RESOLUTION 8'h08
`define OFS_STATUS 8'h0c
`define OFS_DATA_ONE 8'h10
`define OFS_DATA_TWO 8'h14
`define OFS_DATA_ONE_CLR 8'h18
`define OFS_DATA_TWO_CLR 8'h1c
`define OFS_FORMAT 8'h20
`define OFS_CONV_COUNT 8'h24

// ------------------------------------------------------------
// Fields and values
// ------------------------------------------------------------
`define CMD_START_BIT 0
`define CMD_SAMPLE_BIT 1
`define CMD_HALT_BIT 2
`define CMD_STOP_BIT 3
`define CMD_CLEAR_BIT 4
`define CMD_ARG_MSB 15
`define CMD_ARG_LSB 8
`define ST_READY_BIT 0
`define ST_RUN_BIT 1
`define ST_ENABLED_BIT 2
`define ST_CONT_BIT 3
`define ST_OVERRUN_BIT 4
`define POWER_OFF_CODE 8'h00
`define POWER_LOW_CODE 8'h01
`define POWER_MEDIUM_CODE 8'h02
`define POWER_HIGH_CODE 8'h03
`define RES_MIN 8'd7
`define RES_MAX 8'd13
`define RES_DEFAULT 4'd10
`define CALC_INTERVAL_DEFAULT 16'd33
`endif

// ---- logic/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;

  typedef enum logic [1:0] {E_IDLE, E_INTEG, E_CALC} phase_t;

  typedef struct packed {
    phase_t phase;
    logic [15:0] timer;
    logic [13:0] cnt_one;
    logic [13:0] cnt_two;
    logic eoc;
    logic [13:0] n_one;
    logic [13:0] n_two;
  } engine_state_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] power;
    logic enabled;
    logic running;
    logic continuous;
    logic [7:0] remain;
    logic [3:0] res;
    logic signed_fmt;
    logic ready;
    logic overrun;
    logic [15:0] data_one;
    logic [15:0] data_two;
    logic [15:0] conv_count;
    logic [1:0] sync1;
    logic [1:0] sync2;
  } ctrl_state_t;

endpackage

// ---- logic/conv_if.sv ----
`timescale 1ns/10ps
interface conv_if;
  logic run;
  logic [3:0] res;
  logic [15:0] calc;
  logic comp_one;
  logic comp_two;
  logic eoc;
  logic [13:0] n_one;
  logic [13:0] n_two;

  modport ctrl (output run, res, calc, comp_one, comp_two, input eoc, n_one, n_two);
  modport eng (input run, res, calc, comp_one, comp_two, output eoc, n_one, n_two);
endinterface

// ---- logic/incr_engine.sv ----
`timescale 1ns/10ps
module incr_engine import adc_ctrl_pkg::*; (
  input wire logic clk, // Data clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  conv_if.eng cv // Control side.
);

  engine_state_t st;
  engine_state_t next_st;
  logic [15:0] integ_last;

  // ------------------------------------------------------------
  // Integrate and calculate sequencer
  // ------------------------------------------------------------
  // One integrator operation per four data clocks, so 2^(res+2) clocks give 2^res operations.
  always_comb begin
    next_st = st;
    next_st.eoc = 1'b0;
    integ_last = 16'((17'd1 << (cv.res + 4'd2)) - 17'd1);
    if (!cv.run) begin
      next_st.phase = E_IDLE;
      next_st.timer = 16'h0000;
      next_st.cnt_one = 14'h0000;
      next_st.cnt_two = 14'h0000;
    end else begin
      case (st.phase)
        E_IDLE: begin
          next_st.phase = E_INTEG;
          next_st.timer = 16'h0000;
        end
        E_INTEG: begin
          if (st.timer[1:0] == 2'h3) begin
            next_st.cnt_one = st.cnt_one + 14'(cv.comp_one);
            next_st.cnt_two = st.cnt_two + 14'(cv.comp_two);
          end
          if (st.timer == integ_last) begin
            next_st.phase = E_CALC;
            next_st.timer = 16'h0000;
          end else begin
            next_st.timer = st.timer + 16'h0001;
          end
        end
        E_CALC: begin
          if (st.timer + 16'h0001 >= cv.calc) begin
            next_st.eoc = 1'b1;
            next_st.n_one = st.cnt_one;
            next_st.n_two = st.cnt_two;
            next_st.cnt_one = 14'h0000;
            next_st.cnt_two = 14'h0000;
            next_st.timer = 16'h0000;
            next_st.phase = E_INTEG;
          end else begin
            next_st.timer = st.timer + 16'h0001;
          end
        end
        default: begin
          next_st.phase = E_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cv.eoc = st.eoc;
  assign cv.n_one = st.n_one;
  assign cv.n_two = st.n_two;

endmodule // incr_engine

// ---- logic/adc_ctrl_top.sv ----
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "adc_ctrl_params.svh"
module adc_ctrl_top import adc_ctrl_pkg::*; #(
  parameter logic [3:0] STATIC_RES = `RES_DEFAULT,
  parameter logic [15:0] CALC_INTERVAL = `CALC_INTERVAL_DEFAULT
) (
  input wire logic clk, // Data clock, 100 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic comp_one, // Comparator of integrator one, asynchronous.
  input wire logic comp_two, // Comparator of integrator two, asynchronous.
  output logic [1:0] analog_power, // Power code of both integrators.
  output logic integ_enable, // Integrators enabled while converting.
  output logic counter_enable // Digital counting logic enabled.
);

  ctrl_state_t st;
  ctrl_state_t next_st;
  conv_if cv();

  logic access;
  logic done;
  logic addr_ok;
  logic [7:0] arg;
  logic [31:0] rd_word;
  logic [31:0] status_word;

  // ------------------------------------------------------------
  // Result formatting
  // ------------------------------------------------------------
  // The count can reach 2^res when the comparator is high every time; it is clamped
  // to the top code rather than wrapping to zero.
  function automatic logic [15:0] fmt_result(
    input logic [13:0] n,
    input logic [3:0] r,
    input logic sgn
  );
    logic [14:0] full;
    logic [13:0] c;
    logic [15:0] half;
    full = 15'd1 << r;
    if ({1'b0, n} >= full) begin
      c = 14'(full - 15'd1);
    end else begin
      c = n;
    end
    half = 16'd1 << (r - 4'd1);
    if (sgn) begin
      fmt_result = {2'b00, c} - half;
    end else begin
      fmt_result = {2'b00, c};
    end
  endfunction

  // ------------------------------------------------------------
  // Engine connection
  // ------------------------------------------------------------
  assign cv.run = st.running;
  assign cv.res = st.res;
  assign cv.calc = CALC_INTERVAL;
  assign cv.comp_one = st.sync2[0];
  assign cv.comp_two = st.sync2[1];

  incr_engine u_engine (
    .clk(clk),
    .arst_n(arst_n),
    .cv(cv.eng)
  );

  // ------------------------------------------------------------
  // Address decode and read mux
  // ------------------------------------------------------------
  always_comb begin
    status_word = 32'h00000000;
    status_word[`ST_READY_BIT] = st.ready;
    status_word[`ST_RUN_BIT] = st.running;
    status_word[`ST_ENABLED_BIT] = st.enabled;
    status_word[`ST_CONT_BIT] = st.continuous;
    status_word[`ST_OVERRUN_BIT] = st.overrun;
    status_word[15:8] = st.remain;
    status_word[19:16] = st.res;
    status_word[25:24] = st.power[1:0];
  end

  always_comb begin
    addr_ok = 1'b1;
    rd_word = 32'h00000000;
    if (paddr == `OFS_COMMAND) begin
      rd_word = 32'h00000000;
    end else if (paddr == `OFS_POWER) begin
      rd_word = {24'h000000, st.power};
    end else if (paddr == `OFS_RESOLUTION) begin
      rd_word = {28'h0000000, st.res};
    end else if (paddr == `OFS_STATUS) begin
      rd_word = status_word;
    end else if (paddr == `OFS_DATA_ONE || paddr == `OFS_DATA_ONE_CLR) begin
      rd_word = {16'h0000, st.data_one};
    end else if (paddr == `OFS_DATA_TWO || paddr == `OFS_DATA_TWO_CLR) begin
      rd_word = {16'h0000, st.data_two};
    end else if (paddr == `OFS_FORMAT) begin
      rd_word = {31'h00000000, st.signed_fmt};
    end else if (paddr == `OFS_CONV_COUNT) begin
      rd_word = {16'h0000, st.conv_count};
    end else begin
      addr_ok = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.sync1 = {comp_two, comp_one};
    next_st.sync2 = st.sync1;
    access = psel & penable;
    done = access & st.pready;
    arg = pwdata[`CMD_ARG_MSB:`CMD_ARG_LSB];

    // The answer is prepared one cycle into the access phase; writes and
    // read-side clears take effect only at the edge that completes the transfer.
    if (access && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.pslverr = ~addr_ok;
      next_st.prdata = pwrite ? 32'h00000000 : rd_word;
    end

    if (done && pwrite && addr_ok) begin
      if (paddr == `OFS_COMMAND) begin
        if (pwdata[`CMD_START_BIT]) begin
          next_st.enabled = 1'b1;
          next_st.running = 1'b0;
          next_st.continuous = 1'b0;
          next_st.remain = 8'h00;
          next_st.ready = 1'b0;
          next_st.overrun = 1'b0;
          if (arg <= `POWER_HIGH_CODE) begin
            next_st.power = arg;
          end
        end
        if (pwdata[`CMD_SAMPLE_BIT] && next_st.enabled) begin
          next_st.running = 1'b1;
          next_st.remain = arg;
          next_st.continuous = (arg == 8'h00);
        end
        if (pwdata[`CMD_HALT_BIT]) begin
          next_st.running = 1'b0;
        end
        if (pwdata[`CMD_STOP_BIT]) begin
          next_st.power = `POWER_OFF_CODE;
          next_st.enabled = 1'b0;
          next_st.running = 1'b0;
        end
        if (pwdata[`CMD_CLEAR_BIT]) begin
          next_st.ready = 1'b0;
          next_st.overrun = 1'b0;
        end
      end else if (paddr == `OFS_POWER) begin
        // Codes above high are ignored so the analog bias never sees an undefined code.
        // A disabled converter keeps its integrators dark; only start may power them.
        if (pwdata[7:0] <= `POWER_HIGH_CODE && st.enabled) begin
          next_st.power = pwdata[7:0];
        end
      end else if (paddr == `OFS_RESOLUTION) begin
        if (pwdata[7:0] >= `RES_MIN && pwdata[7:0] <= `RES_MAX) begin
          next_st.res = pwdata[3:0];
          next_st.running = 1'b0;
        end
      end else if (paddr == `OFS_FORMAT) begin
        next_st.signed_fmt = pwdata[0];
      end
    end

    if (done && !pwrite) begin
      if (paddr == `OFS_DATA_ONE_CLR || paddr == `OFS_DATA_TWO_CLR) begin
        next_st.ready = 1'b0;
      end
    end

    // End of conversion is applied after the clears, so a result that lands in
    // the clearing cycle still raises the flag.
    if (cv.eoc && st.running) begin
      next_st.data_one = fmt_result(cv.n_one, st.res, st.signed_fmt);
      next_st.data_two = fmt_result(cv.n_two, st.res, st.signed_fmt);
      next_st.overrun = st.overrun | st.ready;
      next_st.ready = 1'b1;
      next_st.conv_count = st.conv_count + 16'h0001;
      if (next_st.running && !st.continuous) begin
        next_st.remain = st.remain - 8'h01;
        if (st.remain == 8'h01) begin
          next_st.running = 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.res <= STATIC_RES;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign analog_power = st.power[1:0];
  assign integ_enable = st.running;
  assign counter_enable = st.enabled;

endmodule // adc_ctrl_top

// ---- verif/comp_model.sv ----
`timescale 1ns/10ps
module comp_model (
  input wire logic clk, // Data clock.
  input wire logic level_one, // Input one above ground when high.
  input wire logic level_two, // Input two above ground when high.
  output logic comp_one, // Comparator of integrator one.
  output logic comp_two // Comparator of integrator two.
);
  // The comparators settle a clock after the input moves, like a real slicer.
  always_ff @(posedge clk) begin
    comp_one <= level_one;
    comp_two <= level_two;
  end
endmodule // comp_model

// ---- verif/adc_ctrl_checker.sv ----
`timescale 1ns/10ps
module adc_ctrl_checker (
  input wire logic clk, // Data clock.
  input wire logic arst_n, // Reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic pready, // APB ready.
  input wire logic [1:0] analog_power, // Integrator power code.
  input wire logic integ_enable, // Integrators running.
  input wire logic counter_enable // Counting logic enabled.
);
  logic wr;
  logic cmd;
  assign wr = psel && penable && pready && pwrite;
  assign cmd = wr && paddr == 8'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_dark_idle: assert property (!counter_enable |-> analog_power == 2'h0)
    else $error("integrators powered while disabled");
  chk_integ_gated: assert property (integ_enable |-> counter_enable)
    else $error("integrators run while disabled");
  chk_stop_off: assert property (cmd && pwdata[3] |-> ##2 !counter_enable && !integ_enable)
    else $error("stop left the converter on");
  chk_start_power: assert property (cmd && pwdata[0] && !pwdata[3] && pwdata[15:10] == 6'h0
    |-> ##2 counter_enable && analog_power == $past(pwdata[9:8], 2))
    else $error("start did not apply power");
  chk_halt_now: assert property (cmd && pwdata[2] |-> ##2 !integ_enable)
    else $error("halt did not stop conversion");
  chk_res_stops: assert property (wr && paddr == 8'h08 && pwdata >= 32'd7 && pwdata <= 32'd13
    |-> ##2 !integ_enable)
    else $error("resolution write left conversion running");
  chk_power_live: assert property (wr && paddr == 8'h04 && pwdata <= 32'd3 && counter_enable
    |-> ##2 analog_power == $past(pwdata[1:0], 2))
    else $error("power change not applied");
  chk_sample_gate: assert property (cmd && pwdata[1] && !pwdata[0] && !counter_enable
    |-> ##2 !integ_enable)
    else $error("sampling started while disabled");
  chk_run_cause: assert property ($rose(integ_enable)
    |-> $past(cmd && pwdata[1], 1) || $past(cmd && pwdata[1], 2))
    else $error("conversion started without command");
  cover property (cmd && pwdata[1] && counter_enable);
  cover property ($fell(integ_enable) && counter_enable);
  cover property (cmd && pwdata[3]);
endmodule // adc_ctrl_checker

bind adc_ctrl_top adc_ctrl_checker chk (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .analog_power, .integ_enable, .counter_enable);

// ---- verif/tb_dual_incremental_adc_control.sv ----
`timescale 1ns/10ps
module tb_dual_incremental_adc_control;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, lv1, lv2, er;
  logic comp_one, comp_two, integ_enable, counter_enable;
  logic [1:0] analog_power;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int num_errors = 0;
  int samples_checked = 0;

  // Resolution 7 keeps one conversion near 517 clocks.
  adc_ctrl_top #(.STATIC_RES(4'd7), .CALC_INTERVAL(16'd4)) dut (
    .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .comp_one, .comp_two, .analog_power, .integ_enable, .counter_enable);
  comp_model far (.clk, .level_one(lv1), .level_two(lv2), .comp_one, .comp_two);

  always #5 clk = ~clk;

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("pready", 32'h1, 32'h0);
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge lets the release settle before the next setup drives psel.
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string s);
    xfer(1'b0, a, 32'h0);
    chk(s, e, rd);
    chk("slverr", 32'h0, {31'h0, er});
  endtask

  task automatic pins(input logic [3:0] e);
    repeat (2) @(posedge clk);
    chk("pins", {28'h0, e}, {28'h0, integ_enable, counter_enable, analog_power});
  endtask

  // Polling is far quicker than a conversion, so no result is missed.
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      xfer(1'b0, 8'h0c, 32'h0);
      k++;
    end while (rd[0] !== 1'b1 && k < 400);
    chk("ready", 32'h1, {31'h0, rd[0]});
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    stop_test();
  end

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lv1 = 1'b1;
    lv2 = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    pins(4'h0);
    rdc(8'h0c, 32'h0007_0000, "status");
    wr(8'h00, 32'h0000_0102);
    pins(4'h0);
    wr(8'h00, 32'h0000_0301);
    pins(4'h7);
    for (int p = 0; p < 4; p++) begin
      wr(8'h04, 32'(p));
      pins({2'b01, p[1:0]});
    end
    wr(8'h04, 32'h4);
    pins(4'h7);
    wr(8'h00, 32'h0000_0202);
    pins(4'hf);
    wr(8'h04, 32'h1);
    pins(4'hd);
    wait_ready();
    rdc(8'h10, 32'h7f, "data1");
    rdc(8'h14, 32'h0, "data2");
    rdc(8'h18, 32'h7f, "data1clr");
    rdc(8'h0c, 32'h0107_0106, "status");
    wait_ready();
    rdc(8'h0c, 32'h0107_0005, "status");
    rdc(8'h24, 32'h2, "count");
    wr(8'h00, 32'h10);
    rdc(8'h0c, 32'h0107_0004, "status");
    rdc(8'h10, 32'h7f, "data1");
    lv1 <= 1'b0;
    lv2 <= 1'b1;
    wr(8'h20, 32'h1);
    wr(8'h00, 32'h2);
    wait_ready();
    rdc(8'h10, 32'hffc0, "data1");
    rdc(8'h1c, 32'h3f, "data2clr");
    wait_ready();
    pins(4'hd);
    wr(8'h00, 32'h4);
    pins(4'h5);
    wr(8'h00, 32'h2);
    pins(4'hd);
    wr(8'h08, 32'h8);
    pins(4'h5);
    wr(8'h08, 32'he);
    xfer(1'b0, 8'h0c, 32'h0);
    chk("res", 32'h8, {28'h0, rd[19:16]});
    wr(8'h00, 32'h8);
    pins(4'h0);
    wr(8'h00, 32'h2);
    pins(4'h0);
    wr(8'h04, 32'h3);
    pins(4'h0);
    xfer(1'b0, 8'h28, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    stop_test();
  end
endmodule // tb_dual_incremental_adc_control
